// *** lvds_link_receiver.sv ***
// Purpose: Panel-side receiver model rebuilding words
// Assumes: Pixel period of PERIOD_CYC core cycles
// Notes:   Slots read mid-bit, timed from the clock's fall
`timescale 1ns/1ps
module lvds_link_receiver
  import lvds_pkg::*;
#(
  parameter int PERIOD_CYC = 32
) (
  input  wire logic      clk,
  input  wire lane_vec_t lanes,
  input  wire logic      fwd,
  input  wire logic      oe,
  output pixel_word_t    word,
  output logic           valid
);
  lane_vec_t [28:0]  hist = '0;
  logic [WORD_W-1:0] flat = '0;
  logic              fwd_q = 1'b0;
  int                cnt = 0;
  // Fall opens slot 2; history lets slots 0 and 1 be read back
  always @(posedge clk) begin
    hist = {hist[27:0], lanes};
    valid <= 1'b0;
    if (cnt == 1) begin
      for (int l = 0; l < LANES; l++)
        for (int s = 0; s < SLOTS; s++)
          flat[l * SLOTS + s] = hist[28 - s * PERIOD_CYC / 7][l];
      word <= flat;
      valid <= 1'b1;
    end
    if (cnt != 0) cnt--;
    if (oe && fwd_q && !fwd) cnt = 20;
    fwd_q = fwd;
  end
endmodule

// *** lvds_pixel_serializer.sv ***
// Purpose: Parallel pixel word to four serial lanes plus forwarded clock
// Assumes: Pixel clock and straps are asynchronous and sampled by CLOCK
// Notes:   Serial bit rate is derived from the measured pixel period
`timescale 1ns/1ps
module lvds_pixel_serializer
  import lvds_pkg::*;
#(
  parameter int PERIOD_W   = PERIOD_W_DEF,
  parameter int MISS_LIMIT = MISS_LIMIT_DEF,
  parameter int LOCK_EDGES = LOCK_EDGES_DEF
) (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic        PIXEL_CLOCK_IN,
  input  wire logic        STROBE_EDGE_SELECT,
  input  wire logic        POWER_DOWN_N,
  input  wire pixel_word_t PARALLEL_PIXEL_IN,
  output lane_vec_t        SERIAL_LANE_POS,
  output lane_vec_t        SERIAL_LANE_NEG,
  output logic             FORWARDED_CLOCK_POS,
  output logic             FORWARDED_CLOCK_NEG,
  output logic             LINK_OE,
  output logic             LOCKED
);

  typedef enum logic [2:0] {
    ST_OFF     = 3'b001,
    ST_ACQUIRE = 3'b010,
    ST_RUN     = 3'b100
  } link_state_t;

  localparam int ACC_W = PERIOD_W + 1;
  localparam logic [ACC_W-1:0] SLOT_STEP = ACC_W'(SLOTS);
  localparam logic [2:0] LAST_SLOT = 3'(SLOTS - 1);
  localparam logic [PERIOD_W-1:0] MISS_CNT = PERIOD_W'(MISS_LIMIT);
  localparam logic [2:0] LOCK_CNT = 3'(LOCK_EDGES - 1);

  // Reset release through two flops
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rst_sync_q <= RST_SYNC_INIT;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // All pins but CLOCK and RESETN cross into the core domain together
  logic [WORD_W+2:0] pins_s;
  pixel_word_t       data_s;
  logic              pclk_s;
  logic              strap_s;
  logic              pwr_on_s;

  lvds_sync2 #(
    .WIDTH(WORD_W + 3)
  ) i_lvds_sync2 (
    .clk  (CLOCK),
    .rst_n(rst_n),
    .d    ({PARALLEL_PIXEL_IN, STROBE_EDGE_SELECT, POWER_DOWN_N, PIXEL_CLOCK_IN}),
    .q    (pins_s)
  );

  assign data_s   = pixel_word_t'(pins_s[WORD_W+2:3]);
  assign strap_s  = pins_s[2];
  assign pwr_on_s = pins_s[1];
  assign pclk_s   = pins_s[0];

  link_state_t          state_q,  state_d;
  logic                 pclk_prev_q, pclk_prev_d;
  pixel_word_t          data_old_q, data_old_d;
  pixel_word_t          word_q,   word_d;
  logic [PERIOD_W-1:0]  cnt_q,    cnt_d;
  logic [PERIOD_W-1:0]  period_q, period_d;
  logic [ACC_W-1:0]     acc_q,    acc_d;
  logic [2:0]           slot_q,   slot_d;
  logic [2:0]           edges_q,  edges_d;
  lane_vec_t            lane_q,   lane_d;
  logic                 fclk_q,   fclk_d;
  logic                 oe_q,     oe_d;

  logic                 rise;
  logic                 fall;
  logic                 strobe;
  logic                 missing;
  logic [ACC_W-1:0]     acc_sum;
  logic                 bit_en;

  assign rise    = pclk_s & ~pclk_prev_q;
  assign fall    = ~pclk_s & pclk_prev_q;
  assign strobe  = strap_s ? rise : fall;
  assign missing = (cnt_q == MISS_CNT);
  assign acc_sum = acc_q + SLOT_STEP;
  // Fractional divider: seven bit enables per measured period
  assign bit_en  = (acc_sum >= {1'b0, period_q});

  always_comb begin
    state_d     = state_q;
    pclk_prev_d = pclk_s;
    // Sample seen just before the edge, so hold time is respected
    data_old_d  = data_s;
    word_d      = word_q;
    cnt_d       = missing ? cnt_q : cnt_q + 1'b1;
    period_d    = period_q;
    acc_d       = acc_q;
    slot_d      = slot_q;
    edges_d     = edges_q;
    lane_d      = '0;
    fclk_d      = 1'b0;
    oe_d        = 1'b1;

    if (strobe) begin
      cnt_d    = '0;
      period_d = cnt_q + 1'b1;
    end

    case (state_q)
      ST_OFF: begin
        oe_d = 1'b0;
        if (pwr_on_s) begin
          state_d = ST_ACQUIRE;
        end
      end
      ST_ACQUIRE: begin
        // Lock needs only a few edges, far inside the lock budget
        if (strobe) begin
          edges_d = edges_q + 1'b1;
          if (edges_q == LOCK_CNT) begin
            state_d = ST_RUN;
            word_d  = data_old_q;
            slot_d  = '0;
            acc_d   = '0;
            lane_d  = lane_slot_bits(data_old_q, 3'h0);
            fclk_d  = FWD_CLK_PATTERN[0];
          end
        end
      end
      ST_RUN: begin
        if (strobe) begin
          // New word restarts the slot count, absorbing period drift
          word_d = data_old_q;
          slot_d = '0;
          acc_d  = '0;
          lane_d = lane_slot_bits(data_old_q, 3'h0);
          fclk_d = FWD_CLK_PATTERN[0];
        end else begin
          lane_d = lane_q;
          fclk_d = fclk_q;
          if (bit_en && slot_q != LAST_SLOT) begin
            slot_d = slot_q + 1'b1;
            acc_d  = acc_sum - {1'b0, period_q};
            lane_d = lane_slot_bits(word_q, slot_q + 1'b1);
            fclk_d = FWD_CLK_PATTERN[slot_q + 1'b1];
          end else if (!bit_en) begin
            acc_d = acc_sum;
          end
        end
      end
      default: begin
        state_d = ST_OFF;
        oe_d    = 1'b0;
      end
    endcase

    // Lost clock: drive low and relock on its return
    if (missing && state_q != ST_OFF) begin
      state_d = ST_ACQUIRE;
      edges_d = '0;
      lane_d  = '0;
      fclk_d  = 1'b0;
    end

    // Power-down wins over everything; state, edges, slot, divider and outputs fall back to reset values
    if (!pwr_on_s) begin
      state_d = ST_OFF;
      edges_d = '0;
      slot_d  = '0;
      acc_d   = '0;
      lane_d  = '0;
      fclk_d  = 1'b0;
      oe_d    = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_OFF;
      pclk_prev_q <= 1'b0;
      data_old_q  <= '0;
      word_q      <= '0;
      cnt_q       <= '0;
      period_q    <= '0;
      acc_q       <= '0;
      slot_q      <= '0;
      edges_q     <= '0;
      lane_q      <= '0;
      fclk_q      <= 1'b0;
      oe_q        <= 1'b0;
    end else begin
      state_q     <= state_d;
      pclk_prev_q <= pclk_prev_d;
      data_old_q  <= data_old_d;
      word_q      <= word_d;
      cnt_q       <= cnt_d;
      period_q    <= period_d;
      acc_q       <= acc_d;
      slot_q      <= slot_d;
      edges_q     <= edges_d;
      lane_q      <= lane_d;
      fclk_q      <= fclk_d;
      oe_q        <= oe_d;
    end
  end

  // Legs forced low while disabled; the pad ring floats them on LINK_OE
  assign SERIAL_LANE_POS     = oe_q ? lane_q : '0;
  assign SERIAL_LANE_NEG     = oe_q ? ~lane_q : '0;
  assign FORWARDED_CLOCK_POS = oe_q & fclk_q;
  assign FORWARDED_CLOCK_NEG = oe_q & ~fclk_q;
  assign LINK_OE             = oe_q;
  assign LOCKED              = (state_q == ST_RUN);

endmodule

// *** lvds_pixel_serializer_checker.sv ***
// Purpose: Port-level checks of the pixel serializer
// Assumes: Pixel period of at least seven core cycles
// Notes:   Bound to every serializer instance
`timescale 1ns/1ps
module lvds_pixel_serializer_checker
  import lvds_pkg::*;
(
  input wire logic      CLOCK,
  input wire logic      RESETN,
  input wire logic      POWER_DOWN_N,
  input wire lane_vec_t SERIAL_LANE_POS,
  input wire lane_vec_t SERIAL_LANE_NEG,
  input wire logic      FORWARDED_CLOCK_POS,
  input wire logic      FORWARDED_CLOCK_NEG,
  input wire logic      LINK_OE,
  input wire logic      LOCKED
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  sequence s_pd_held; !POWER_DOWN_N [*5]; endsequence
  // Slots 5,6,0,1 high; a dropped enable may cut the run short
  sequence s_fwd_hi; (FORWARDED_CLOCK_POS || !LINK_OE) [*4]; endsequence
  property p_lane; LINK_OE |-> SERIAL_LANE_NEG == ~SERIAL_LANE_POS; endproperty
  a_lane: assert property (p_lane) else $error("lane legs");
  property p_fclk; LINK_OE |-> FORWARDED_CLOCK_NEG == ~FORWARDED_CLOCK_POS; endproperty
  a_fclk: assert property (p_fclk) else $error("clock legs");
  property p_pd_off; s_pd_held |-> !LINK_OE && !LOCKED; endproperty
  a_pd_off: assert property (p_pd_off) else $error("late power-down");
  property p_quiet;
    !LINK_OE |-> {SERIAL_LANE_POS, SERIAL_LANE_NEG, FORWARDED_CLOCK_POS,
                  FORWARDED_CLOCK_NEG, LOCKED} == '0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs while off");
  property p_lock_oe; LOCKED |-> LINK_OE; endproperty
  a_lock_oe: assert property (p_lock_oe) else $error("locked, disabled");
  property p_fwd_hi; $rose(FORWARDED_CLOCK_POS) |-> s_fwd_hi; endproperty
  a_fwd_hi: assert property (p_fwd_hi) else $error("short high");
  property p_fwd_lo; $fell(FORWARDED_CLOCK_POS) && LINK_OE |-> !FORWARDED_CLOCK_POS [*3];
  endproperty
  a_fwd_lo: assert property (p_fwd_lo) else $error("short low");
  property p_relock; $rose(POWER_DOWN_N) |-> !LOCKED [*8]; endproperty
  a_relock: assert property (p_relock) else $error("early lock");
endmodule

bind lvds_pixel_serializer lvds_pixel_serializer_checker i_lvds_pixel_serializer_checker (.*);

// *** lvds_pixel_serializer_tb.sv ***
// Purpose: Self-checking bench for the pixel serializer
// Assumes: Pixel clock of 160 ns, stopped on demand
// Notes:   Word is garbage around the unused pixel edge
`timescale 1ns/1ps
module lvds_pixel_serializer_tb
  import lvds_pkg::*;
;
  logic        CLOCK = 0, RESETN = 0, PIXEL_CLOCK_IN = 0, run = 0;
  logic        STROBE_EDGE_SELECT = 0, POWER_DOWN_N = 1;
  logic        FORWARDED_CLOCK_POS, FORWARDED_CLOCK_NEG, LINK_OE, LOCKED, rx_valid;
  lane_vec_t   SERIAL_LANE_POS, SERIAL_LANE_NEG;
  pixel_word_t PARALLEL_PIXEL_IN = '0, rx_word;
  logic [7:0]  n = 8'h0;
  logic [1:0]  q = 2'h0;
  logic [2:0]  ph = 3'h0;
  int          n_fail = 0, checks_done = 0, cycles = 0;
  lvds_pixel_serializer #(.MISS_LIMIT(200)) i_lvds_pixel_serializer (.*);
  lvds_link_receiver i_lvds_link_receiver (.clk(CLOCK), .lanes(SERIAL_LANE_POS),
    .fwd(FORWARDED_CLOCK_POS), .oe(LINK_OE), .word(rx_word), .valid(rx_valid));
  initial forever #2.5 CLOCK = ~CLOCK;
  // Wrong-edge capture would pick up the inverted garbage word
  // One pixel quarter every eight core cycles gives the 160 ns pixel clock
  always @(posedge CLOCK) begin
    if (run) begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) begin
        q = q + 2'h1;
        PIXEL_CLOCK_IN <= STROBE_EDGE_SELECT ? ~q[1] : q[1];
        if (q == 2'h1) PARALLEL_PIXEL_IN <= ~PARALLEL_PIXEL_IN;
        if (q == 2'h3) n = n + 8'h1;
        if (q == 2'h3) PARALLEL_PIXEL_IN <= {n[3:0], n ^ 8'hA5, ~n, n};
      end
    end
  end
  task automatic chk(input string s, input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic stream(input int words);
    logic [7:0] last;
    last = 8'h0;
    for (int w = 0; w < words; w++) begin
      @(posedge CLOCK);
      for (int i = 0; i < 600 && rx_valid !== 1'b1; i++) @(posedge CLOCK);
      chk("rx_valid", 8'h1, rx_valid);
      chk("green", ~rx_word.red, rx_word.green);
      chk("blue", rx_word.red ^ 8'hA5, rx_word.blue);
      chk("control", rx_word.red[3:0], rx_word[27:24]);
      if (w > 0) chk("red", last + 8'h1, rx_word.red);
      last = rx_word.red;
    end
  endtask
  task automatic t_falling();
    run = 1'b1;
    stream(6);
  endtask
  task automatic t_clock_stop();
    run = 1'b0;
    repeat (260) @(posedge CLOCK);
    chk("LOCKED", 8'h0, LOCKED);
    chk("LINK_OE", 8'h1, LINK_OE);
    chk("lanes", 8'h0, SERIAL_LANE_POS);
    run = 1'b1;
    stream(4);
  endtask
  task automatic t_power_down();
    POWER_DOWN_N <= 1'b0;
    repeat (20) @(posedge CLOCK);
    chk("LINK_OE", 8'h0, LINK_OE);
    chk("LOCKED", 8'h0, LOCKED);
    run = 1'b0;
    STROBE_EDGE_SELECT <= 1'b1;
    repeat (200) @(posedge CLOCK);
    POWER_DOWN_N <= 1'b1;
    repeat (40) @(posedge CLOCK);
    chk("LOCKED", 8'h0, LOCKED);
    run = 1'b1;
    stream(6);
  endtask
  initial begin
    repeat (12) @(posedge CLOCK);
    RESETN <= 1'b1;
    repeat (4) @(posedge CLOCK);
    t_falling();
    t_clock_stop();
    t_power_down();
    finish_test();
  end
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 8000) begin
      n_fail++;
      finish_test();
    end
  end
endmodule

// *** lvds_pkg.sv ***
// Purpose: Shared constants, carriers and lane mapping for the pixel serializer
// Assumes: Core clock of 200 MHz, pixel clock far slower than the core clock
// Notes:   Lane mapping is the integrator's fixed choice, kept in one function
package lvds_pkg;

  localparam int LANES = 4;
  localparam int SLOTS = 7;
  localparam int WORD_W = LANES * SLOTS;

  // Default period measure width and clock-loss limit, in core cycles
  localparam int PERIOD_W_DEF = 12;
  localparam int MISS_LIMIT_DEF = 12'hFA0;
  localparam int LOCK_EDGES_DEF = 3;

  localparam logic [SLOTS-1:0] FWD_CLK_PATTERN = 7'h63;
  localparam logic [1:0] RST_SYNC_INIT = 2'h0;

  typedef struct packed {
    logic       spare;
    logic       data_valid;
    logic       frame_sync;
    logic       line_sync;
    logic [7:0] blue;
    logic [7:0] green;
    logic [7:0] red;
  } pixel_word_t;

  typedef logic [LANES-1:0] lane_vec_t;

  // Bit of every lane for one slot; lane l carries word bits l*7 .. l*7+6
  function automatic lane_vec_t lane_slot_bits(input pixel_word_t w,
                                               input logic [2:0] slot);
    logic [WORD_W-1:0] flat;
    lane_vec_t         v;
    flat = w;
    v = '0;
    for (int l = 0; l < LANES; l++) begin
      v[l] = flat[l * SLOTS + int'(slot)];
    end
    return v;
  endfunction

endpackage

// *** lvds_sync2.sv ***
// Purpose: Two-stage synchroniser for inputs from outside the core clock
// Assumes: Inputs are levels; the first stage feeds only the second
// Notes:   Reset value is zero on every bit
`timescale 1ns/1ps
module lvds_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      stable_q <= '0;
    end else begin
      meta_q   <= d;
      stable_q <= meta_q;
    end
  end

  assign q = stable_q;

endmodule
